// [hw/exec_pkg.sv]
package exec_pkg;
  localparam int WORD_W = 16;
  localparam int DATA_W = 8;
  localparam int REG_CNT = 32;
  localparam int REG_AW = 5;
  localparam int IO_AW = 5;
  localparam int BIT_AW = 3;
  // status bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;
  localparam int SIGN_BIT = 7;
  localparam int NIB_W = 4;
  localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
  // z pointer halves in the register file
  localparam logic [REG_AW-1:0] Z_LO = 5'h1e;
  localparam logic [REG_AW-1:0] Z_HI = 5'h1f;
  // opcode masks and match values
  localparam logic [WORD_W-1:0] MASK_ONE_REG = 16'hfe0f;
  localparam logic [WORD_W-1:0] INC_VAL = 16'h9403;
  localparam logic [WORD_W-1:0] DEC_VAL = 16'h940a;
  localparam logic [WORD_W-1:0] LSR_VAL = 16'h9406;
  localparam logic [WORD_W-1:0] LDS_VAL = 16'h9000;
  localparam logic [WORD_W-1:0] STS_VAL = 16'h9200;
  localparam logic [WORD_W-1:0] MASK_TWO_REG = 16'hfc00;
  localparam logic [WORD_W-1:0] EQUAL_SKIP_OP_VAL = 16'h1000;
  localparam logic [WORD_W-1:0] CP_VAL = 16'h1400;
  localparam logic [WORD_W-1:0] CPC_VAL = 16'h0400;
  localparam logic [WORD_W-1:0] ADD_VAL = 16'h0c00;
  localparam logic [WORD_W-1:0] AND_VAL = 16'h2000;
  localparam logic [WORD_W-1:0] FLAG_SET_BRANCH_OP_VAL = 16'hf000;
  localparam logic [WORD_W-1:0] FLAG_CLEAR_BRANCH_OP_VAL = 16'hf400;
  localparam logic [WORD_W-1:0] MASK_HI = 16'hf000;
  localparam logic [WORD_W-1:0] REL_JUMP_OP_VAL = 16'hc000;
  localparam logic [WORD_W-1:0] REL_SUBR_CALL_OP_VAL = 16'hd000;
  localparam logic [WORD_W-1:0] CPI_VAL = 16'h3000;
  localparam logic [WORD_W-1:0] MASK_LDI_FF = 16'hff0f;
  localparam logic [WORD_W-1:0] SER_VAL = 16'hef0f;
  localparam logic [WORD_W-1:0] MASK_IO = 16'hff00;
  localparam logic [WORD_W-1:0] CBI_VAL = 16'h9800;
  localparam logic [WORD_W-1:0] IO_BIT_CLEAR_SKIP_OP_VAL = 16'h9900;
  localparam logic [WORD_W-1:0] SBI_VAL = 16'h9a00;
  localparam logic [WORD_W-1:0] IO_BIT_SET_SKIP_OP_VAL = 16'h9b00;
  localparam logic [WORD_W-1:0] MASK_RBIT = 16'hfe08;
  localparam logic [WORD_W-1:0] REG_BIT_CLEAR_SKIP_OP_VAL = 16'hfc00;
  localparam logic [WORD_W-1:0] REG_BIT_SET_SKIP_OP_VAL = 16'hfe00;
  localparam logic [WORD_W-1:0] MASK_LONG = 16'hfe0e;
  localparam logic [WORD_W-1:0] JMP_VAL = 16'h940c;
  localparam logic [WORD_W-1:0] CALL_VAL = 16'h940e;
  localparam logic [WORD_W-1:0] POINTER_JUMP_OP_VAL = 16'h9409;
  localparam logic [WORD_W-1:0] POINTER_SUBR_CALL_OP_VAL = 16'h9509;
  localparam logic [WORD_W-1:0] RET_VAL = 16'h9508;
  localparam logic [WORD_W-1:0] IRQ_BACK_OP_VAL = 16'h9518;
  // byte constants
  localparam logic [DATA_W-1:0] ALL_ONES = 8'hff;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;
  localparam logic [DATA_W-1:0] SIGN_MIN = 8'h80;
  localparam logic [DATA_W-1:0] SIGN_MAX = 8'h7f;
  // program counter steps and cycle counts
  localparam int PC_STEP = 1;
  localparam int SKIP_SHORT = 2;
  localparam int SKIP_LONG = 3;
  localparam logic [1:0] HOLD_NONE = 2'h0;
  localparam logic [1:0] HOLD_ONE = 2'h1;
  localparam logic [1:0] HOLD_TWO = 2'h2;
  localparam logic [1:0] HOLD_THREE = 2'h3;

  typedef enum logic [1:0] {st_exec = 2'b01, st_hold = 2'b10} phase_type;

  function automatic logic hit(logic [WORD_W-1:0] w, logic [WORD_W-1:0] m,
                               logic [WORD_W-1:0] v);
    hit = (w & m) == v;
  endfunction
  function automatic logic [REG_AW-1:0] f_rd(logic [WORD_W-1:0] w);
    f_rd = w[8:4];
  endfunction
  function automatic logic [REG_AW-1:0] f_rr(logic [WORD_W-1:0] w);
    f_rr = {w[9], w[3:0]};
  endfunction
  function automatic logic [REG_AW-1:0] f_rd_hi(logic [WORD_W-1:0] w);
    f_rd_hi = {1'b1, w[7:4]};
  endfunction
  function automatic logic [DATA_W-1:0] f_imm(logic [WORD_W-1:0] w);
    f_imm = {w[11:8], w[3:0]};
  endfunction
  function automatic logic [BIT_AW-1:0] f_bit(logic [WORD_W-1:0] w);
    f_bit = w[2:0];
  endfunction
  function automatic logic [IO_AW-1:0] f_io(logic [WORD_W-1:0] w);
    f_io = w[7:3];
  endfunction
  function automatic logic signed [6:0] f_k7(logic [WORD_W-1:0] w);
    f_k7 = w[9:3];
  endfunction
  function automatic logic signed [11:0] f_k12(logic [WORD_W-1:0] w);
    f_k12 = w[11:0];
  endfunction
  // words that carry a second operand word
  function automatic logic two_word(logic [WORD_W-1:0] w);
    two_word = hit(w, MASK_LONG, JMP_VAL) || hit(w, MASK_LONG, CALL_VAL) ||
               hit(w, MASK_ONE_REG, LDS_VAL) || hit(w, MASK_ONE_REG, STS_VAL);
  endfunction
endpackage

// [hw/branch_skip_compare_execution.sv]
`timescale 1ns/100ps
// Overview of operation
// - increment, decrement, self-and test touch only Z, N, V (and S), one cycle
// - relative jump goes to PC+k+1, pointer jump to Z; two cycles, no flags
// - calls push return address, jump relative or to Z, 3 cycles; returns 4
// - equal-skip skips next word(s) when registers match; no flags
// - compares subtract without storing, update Z,N,V,C,H in one cycle
// - register-bit skips skip when chosen bit is clear or set
// - io-bit skips skip when chosen io bit is clear or set; no flags
// - flag branches jump to PC+k+1 on chosen status bit set or clear
// - equal/unequal follow Z, minus/plus follow N
// - carry-clear and same-higher take on C=0; carry-set and lower on C=1
// - signed greater-equal takes when N xor V is 0; one or two cycles
// - signed less-than takes when N xor V is 1; no flag change
// - half-carry branches follow H
// - transfer-bit branches follow T
// - overflow branches follow V
// - interrupt-state branches follow I
// - io bit set and clear write one bit, two cycles, no flags
// - shifts move bits, fill zero, update Z, C, N, V in one cycle
// - io bit ops reach only io 0x00..0x1f and touch only the addressed bit
module branch_skip_compare_execution #(
  parameter int PC_W = 11,
  parameter int STACK_D = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  output logic [PC_W-1:0] prog_addr_out,
  input wire logic [15:0] prog_word_in,
  input wire logic [15:0] prog_next_word_in,
  output logic [4:0] io_rd_addr_out,
  input wire logic [7:0] io_rd_data_in,
  output logic io_wr_en_out,
  output logic [4:0] io_wr_addr_out,
  output logic [7:0] io_wr_data_out,
  output logic [7:0] io_wr_mask_out,
  output logic [7:0] status_out,
  output logic busy_out,
  input wire logic [4:0] rf_peek_addr_in,
  output logic [7:0] rf_peek_data_out
);
  localparam int SP_W = $clog2(STACK_D);

  ////////////////////////////////////////////////////////////////////////////
  // state
  exec_pkg::phase_type phase;
  logic [1:0] hold_cnt;
  logic [PC_W-1:0] pc;
  logic [7:0] status_register;
  logic [7:0] next_status_register;
  logic [7:0] rf [exec_pkg::REG_CNT];
  logic [PC_W-1:0] stk [STACK_D];
  logic [SP_W-1:0] sp;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire [15:0] w = prog_word_in;
  wire exec = phase == exec_pkg::st_exec;
  wire is_inc = exec_pkg::hit(w, exec_pkg::MASK_ONE_REG, exec_pkg::INC_VAL);
  wire is_dec = exec_pkg::hit(w, exec_pkg::MASK_ONE_REG, exec_pkg::DEC_VAL);
  wire is_lsr = exec_pkg::hit(w, exec_pkg::MASK_ONE_REG, exec_pkg::LSR_VAL);
  wire same_rr = exec_pkg::f_rd(w) == exec_pkg::f_rr(w);
  // the shift-left and self-test forms are add and and with one register twice
  wire is_lsl = exec_pkg::hit(w, exec_pkg::MASK_TWO_REG, exec_pkg::ADD_VAL) && same_rr;
  wire is_tst = exec_pkg::hit(w, exec_pkg::MASK_TWO_REG, exec_pkg::AND_VAL) && same_rr;
  wire is_ser = exec_pkg::hit(w, exec_pkg::MASK_LDI_FF, exec_pkg::SER_VAL);
  wire is_rel_jump_op = exec_pkg::hit(w, exec_pkg::MASK_HI, exec_pkg::REL_JUMP_OP_VAL);
  wire is_rel_subr_call_op = exec_pkg::hit(w, exec_pkg::MASK_HI, exec_pkg::REL_SUBR_CALL_OP_VAL);
  wire is_pointer_jump_op = w == exec_pkg::POINTER_JUMP_OP_VAL;
  wire is_pointer_subr_call_op = w == exec_pkg::POINTER_SUBR_CALL_OP_VAL;
  wire is_ret = w == exec_pkg::RET_VAL;
  wire is_irq_back_op = w == exec_pkg::IRQ_BACK_OP_VAL;
  wire is_equal_skip_op = exec_pkg::hit(w, exec_pkg::MASK_TWO_REG, exec_pkg::EQUAL_SKIP_OP_VAL);
  wire is_cp = exec_pkg::hit(w, exec_pkg::MASK_TWO_REG, exec_pkg::CP_VAL);
  wire is_cpc = exec_pkg::hit(w, exec_pkg::MASK_TWO_REG, exec_pkg::CPC_VAL);
  wire is_cpi = exec_pkg::hit(w, exec_pkg::MASK_HI, exec_pkg::CPI_VAL);
  wire is_reg_bit_clear_skip_op = exec_pkg::hit(w, exec_pkg::MASK_RBIT, exec_pkg::REG_BIT_CLEAR_SKIP_OP_VAL);
  wire is_reg_bit_set_skip_op = exec_pkg::hit(w, exec_pkg::MASK_RBIT, exec_pkg::REG_BIT_SET_SKIP_OP_VAL);
  wire is_io_bit_clear_skip_op = exec_pkg::hit(w, exec_pkg::MASK_IO, exec_pkg::IO_BIT_CLEAR_SKIP_OP_VAL);
  wire is_io_bit_set_skip_op = exec_pkg::hit(w, exec_pkg::MASK_IO, exec_pkg::IO_BIT_SET_SKIP_OP_VAL);
  wire is_sbi = exec_pkg::hit(w, exec_pkg::MASK_IO, exec_pkg::SBI_VAL);
  wire is_cbi = exec_pkg::hit(w, exec_pkg::MASK_IO, exec_pkg::CBI_VAL);
  wire is_flag_set_branch_op = exec_pkg::hit(w, exec_pkg::MASK_TWO_REG, exec_pkg::FLAG_SET_BRANCH_OP_VAL);
  wire is_flag_clear_branch_op = exec_pkg::hit(w, exec_pkg::MASK_TWO_REG, exec_pkg::FLAG_CLEAR_BRANCH_OP_VAL);
  wire is_call = is_rel_subr_call_op || is_pointer_subr_call_op;
  wire is_back = is_ret || is_irq_back_op;
  wire is_cmp = is_cp || is_cpc || is_cpi;
  wire is_shift = is_lsl || is_lsr;
  wire is_unit = is_inc || is_dec || is_tst || is_shift;

  ////////////////////////////////////////////////////////////////////////////
  // operands; immediate forms reach only the upper sixteen registers
  wire hi_form = is_cpi || is_ser;
  wire [4:0] d_idx = hi_form ? exec_pkg::f_rd_hi(w) : exec_pkg::f_rd(w);
  wire [7:0] opa = rf[d_idx];
  wire [7:0] opb = is_cpi ? exec_pkg::f_imm(w) : rf[exec_pkg::f_rr(w)];
  wire [2:0] bsel = exec_pkg::f_bit(w);
  wire [7:0] bmask = exec_pkg::ONE_BYTE << bsel;
  wire [7:0] zp = rf[exec_pkg::Z_HI];
  wire [PC_W-1:0] z_ptr = PC_W'({zp, rf[exec_pkg::Z_LO]});

  ////////////////////////////////////////////////////////////////////////////
  // compare: subtract, keep only the flags
  wire cin = is_cpc && status_register[exec_pkg::FLAG_C];
  wire [8:0] diff = {1'b0, opa} - {1'b0, opb} - {8'h00, cin};
  wire [4:0] hdiff = {1'b0, opa[3:0]} - {1'b0, opb[3:0]} - {4'h0, cin};
  wire [7:0] cres = diff[7:0];
  wire a7 = opa[exec_pkg::SIGN_BIT];
  wire b7 = opb[exec_pkg::SIGN_BIT];
  wire r7 = cres[exec_pkg::SIGN_BIT];
  wire cmp_v = (a7 && !b7 && !r7) || (!a7 && b7 && r7);
  // with carry the zero flag can only stay or clear, so chains compare wide
  wire cmp_z = (cres == exec_pkg::ZERO_BYTE) && (!is_cpc || status_register[exec_pkg::FLAG_Z]);

  ////////////////////////////////////////////////////////////////////////////
  // one-register unit ops
  wire [7:0] shl = {opa[6:0], 1'b0};
  wire [7:0] shr = {1'b0, opa[7:1]};
  wire [7:0] ures = is_inc ? opa + exec_pkg::ONE_BYTE :
                    is_dec ? opa - exec_pkg::ONE_BYTE :
                    is_lsl ? shl : is_lsr ? shr : opa;
  wire uc = is_lsl ? a7 : opa[0];
  wire un = ures[exec_pkg::SIGN_BIT];
  wire uv = is_inc ? ures == exec_pkg::SIGN_MIN :
            is_dec ? ures == exec_pkg::SIGN_MAX :
            is_shift ? un ^ uc : 1'b0;
  wire rf_we = exec && (is_inc || is_dec || is_shift || is_ser);
  wire [7:0] rf_wd = is_ser ? exec_pkg::ALL_ONES : ures;

  ////////////////////////////////////////////////////////////////////////////
  // branch and skip conditions
  // every named flag branch is the generic form with its status bit fixed
  wire flag_bit = status_register[bsel];
  wire br_taken = (is_flag_set_branch_op && flag_bit) || (is_flag_clear_branch_op && !flag_bit);
  wire io_bit = (io_rd_data_in & bmask) != exec_pkg::ZERO_BYTE;
  wire r_bit = (opa & bmask) != exec_pkg::ZERO_BYTE;
  wire skip_take = (is_equal_skip_op && opa == opb) ||
                   (is_reg_bit_clear_skip_op && !r_bit) || (is_reg_bit_set_skip_op && r_bit) ||
                   (is_io_bit_clear_skip_op && !io_bit) || (is_io_bit_set_skip_op && io_bit);
  wire skip_long = exec_pkg::two_word(prog_next_word_in);

  ////////////////////////////////////////////////////////////////////////////
  // next program counter
  wire [PC_W-1:0] pc_inc = pc + PC_W'(exec_pkg::PC_STEP);
  wire [PC_W-1:0] rel_far = pc_inc + PC_W'(exec_pkg::f_k12(w));
  wire [PC_W-1:0] rel_near = pc_inc + PC_W'(exec_pkg::f_k7(w));
  wire [SP_W-1:0] sp_top = sp - SP_W'(exec_pkg::PC_STEP);
  wire [PC_W-1:0] skip_pc = pc + PC_W'(skip_long ? exec_pkg::SKIP_LONG :
                                                   exec_pkg::SKIP_SHORT);
  wire [PC_W-1:0] next_pc = (is_rel_jump_op || is_rel_subr_call_op) ? rel_far :
                            (is_pointer_jump_op || is_pointer_subr_call_op) ? z_ptr :
                            is_back ? stk[sp_top] :
                            br_taken ? rel_near :
                            skip_take ? skip_pc : pc_inc;

  ////////////////////////////////////////////////////////////////////////////
  // cycles beyond the first, held off in the hold phase
  wire [1:0] next_hold = is_back ? exec_pkg::HOLD_THREE :
                         is_call ? exec_pkg::HOLD_TWO :
                         (is_rel_jump_op || is_pointer_jump_op || is_sbi || is_cbi) ? exec_pkg::HOLD_ONE :
                         br_taken ? exec_pkg::HOLD_ONE :
                         (skip_take && skip_long) ? exec_pkg::HOLD_TWO :
                         skip_take ? exec_pkg::HOLD_ONE : exec_pkg::HOLD_NONE;

  ////////////////////////////////////////////////////////////////////////////
  // flag update
  always_comb begin
    next_status_register = status_register;
    if (is_cmp) begin
      next_status_register[exec_pkg::FLAG_C] = diff[8];
      next_status_register[exec_pkg::FLAG_Z] = cmp_z;
      next_status_register[exec_pkg::FLAG_N] = r7;
      next_status_register[exec_pkg::FLAG_V] = cmp_v;
      next_status_register[exec_pkg::FLAG_S] = r7 ^ cmp_v;
      next_status_register[exec_pkg::FLAG_H] = hdiff[exec_pkg::NIB_W];
    end else if (is_unit) begin
      next_status_register[exec_pkg::FLAG_Z] = ures == exec_pkg::ZERO_BYTE;
      next_status_register[exec_pkg::FLAG_N] = un;
      next_status_register[exec_pkg::FLAG_V] = uv;
      next_status_register[exec_pkg::FLAG_S] = un ^ uv;
      if (is_shift) begin
        next_status_register[exec_pkg::FLAG_C] = uc;
      end
    end else if (is_irq_back_op) begin
      next_status_register[exec_pkg::FLAG_I] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: a new word is taken only in the exec phase
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      phase <= exec_pkg::st_exec;
      hold_cnt <= exec_pkg::HOLD_NONE;
      pc <= '0;
      status_register <= exec_pkg::STATUS_RESET;
      sp <= '0;
    end else begin
      unique case (phase)
        exec_pkg::st_exec: begin
          pc <= next_pc;
          status_register <= next_status_register;
          hold_cnt <= next_hold;
          if (next_hold != exec_pkg::HOLD_NONE) begin
            phase <= exec_pkg::st_hold;
          end
          if (is_call) begin
            sp <= sp + SP_W'(exec_pkg::PC_STEP);
          end else if (is_back) begin
            sp <= sp_top;
          end
        end
        exec_pkg::st_hold: begin
          hold_cnt <= hold_cnt - exec_pkg::HOLD_ONE;
          if (hold_cnt == exec_pkg::HOLD_ONE) begin
            phase <= exec_pkg::st_exec;
          end
        end
      endcase
    end
  end

  // stack and register file carry no reset; software fills them first
  always_ff @(posedge clk_in) begin
    if (exec && is_call) begin
      stk[sp] <= pc_inc;
    end
    if (rf_we) begin
      rf[d_idx] <= rf_wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // io bit write, issued with a mask so flag bits beside it stay untouched
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      io_wr_en_out <= 1'b0;
      io_wr_addr_out <= '0;
      io_wr_data_out <= exec_pkg::ZERO_BYTE;
      io_wr_mask_out <= exec_pkg::ZERO_BYTE;
      rf_peek_data_out <= exec_pkg::ZERO_BYTE;
    end else begin
      io_wr_en_out <= exec && (is_sbi || is_cbi);
      io_wr_addr_out <= exec_pkg::f_io(w);
      io_wr_data_out <= is_sbi ? bmask : exec_pkg::ZERO_BYTE;
      io_wr_mask_out <= bmask;
      rf_peek_data_out <= rf[rf_peek_addr_in];
    end
  end

  assign prog_addr_out = pc;
  assign io_rd_addr_out = exec_pkg::f_io(w);
  assign status_out = status_register;
  assign busy_out = phase == exec_pkg::st_hold;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_rel_jump_target: assert property (
    exec && is_rel_jump_op |=> pc == $past(rel_far) && busy_out ##1 !busy_out)
    else $error("relative jump target or length wrong");
  a_call_cycles: assert property (
    exec && is_call |=> busy_out [*2] ##1 !busy_out)
    else $error("call did not take three cycles");
  a_return_cycles: assert property (
    exec && is_back |=> busy_out [*3] ##1 !busy_out)
    else $error("return did not take four cycles");
  a_irq_back_op_sets_i: assert property (
    exec && is_irq_back_op |=> status_register[exec_pkg::FLAG_I])
    else $error("interrupt return left I clear");
  a_skip_short: assert property (
    exec && skip_take && !skip_long |=> pc == $past(pc) + PC_W'(2) ##1 !busy_out)
    else $error("short skip target or length wrong");
  a_branch_keeps_flags: assert property (
    exec && (is_flag_set_branch_op || is_flag_clear_branch_op) |=> status_register == $past(status_register))
    else $error("branch changed flags");
  a_io_single_bit: assert property (
    exec && (is_sbi || is_cbi) |=> io_wr_en_out && $onehot(io_wr_mask_out)
      && (io_wr_data_out & ~io_wr_mask_out) == 8'h00)
    else $error("io bit write touched other bits");
  a_ser_no_flags: assert property (
    exec && is_ser |=> status_register == $past(status_register) && rf[$past(d_idx)] == 8'hff)
    else $error("all-ones load wrong");
  a_lsr_flags: assert property (
    exec && is_lsr |=> !status_register[exec_pkg::FLAG_N] && status_register[exec_pkg::FLAG_C] == $past(opa[0]))
    else $error("right shift flags wrong");
  a_inc_keeps_ch: assert property (
    exec && is_inc |=> status_register[exec_pkg::FLAG_C] == $past(status_register[exec_pkg::FLAG_C])
      && status_register[exec_pkg::FLAG_H] == $past(status_register[exec_pkg::FLAG_H]) && !busy_out)
    else $error("increment touched C or H");

  a_branch_not_taken: assert property (
    exec && (is_flag_set_branch_op || is_flag_clear_branch_op) && !br_taken |=> pc == $past(pc_inc) && !busy_out)
    else $error("untaken branch moved pc or stalled");

  c_branch_taken: cover property (exec && br_taken);
  c_io_bit_write: cover property (exec && (is_sbi || is_cbi));
  c_carry_chain: cover property (exec && is_cpc);
  c_long_skip: cover property (exec && skip_take && skip_long);
  c_irq_return: cover property (exec && is_irq_back_op);
endmodule

// [tb/tb_branch_skip_compare_execution.sv]
`timescale 1ns/100ps
module tb_branch_skip_compare_execution;
  typedef struct packed {logic [3:0] cyc; logic [10:0] pc; logic [7:0] st;} step_type;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [4:0] rf_peek_addr_in = 5'h00;
  logic [15:0] prog_word_in, prog_next_word_in;
  logic [10:0] prog_addr_out;
  logic [4:0] io_rd_addr_out, io_wr_addr_out;
  logic [7:0] io_rd_data_in, io_wr_data_out, io_wr_mask_out, status_out, rf_peek_data_out;
  logic io_wr_en_out, busy_out;
  logic [15:0] mem [0:2047];
  logic [7:0] io [0:31];
  step_type steps [$];
  int n_errors = 0;
  int num_checks = 0;

  branch_skip_compare_execution i_dut (.clk_in(clk_in), .rst_in(rst_in),
    .prog_addr_out(prog_addr_out), .prog_word_in(prog_word_in),
    .prog_next_word_in(prog_next_word_in), .io_rd_addr_out(io_rd_addr_out),
    .io_rd_data_in(io_rd_data_in), .io_wr_en_out(io_wr_en_out),
    .io_wr_addr_out(io_wr_addr_out), .io_wr_data_out(io_wr_data_out),
    .io_wr_mask_out(io_wr_mask_out), .status_out(status_out), .busy_out(busy_out),
    .rf_peek_addr_in(rf_peek_addr_in), .rf_peek_data_out(rf_peek_data_out));

  ////////////////////////////////////////////////////////////////////////////////
  // program store and io space answer at once, like the on-chip memories
  assign prog_word_in = mem[prog_addr_out];
  assign prog_next_word_in = mem[prog_addr_out + 11'h001];
  assign io_rd_data_in = io[io_rd_addr_out];
  always #2.5 clk_in = ~clk_in;
  // io write goes through the mask so a wrong mask would also clobber neighbours
  always @(posedge clk_in) begin
    if (io_wr_en_out === 1'b1) begin
      io[io_wr_addr_out] <= (io[io_wr_addr_out] & ~io_wr_mask_out) |
                            (io_wr_data_out & io_wr_mask_out);
    end
  end
  // watchdog: the full run needs roughly 2200 cycles
  initial begin
    #100000;
    n_errors++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // reset every scenario so each program starts from pc 0 and clear flags
  task automatic wipe();
    rst_in = 1'b1;
    foreach (mem[i]) mem[i] = 16'h0000;
    steps.delete();
    tick(20);
  endtask
  function automatic void add_step(input int c, input int p, input logic [7:0] s);
    steps.push_back(step_type'{4'(c), 11'(p), s});
  endfunction
  // one entry per executed instruction: pc after it, flags, and its length
  task automatic run_steps();
    rst_in = 1'b0;
    foreach (steps[i]) begin
      tick(1);
      chk(16'(prog_addr_out), 16'(steps[i].pc));
      chk(16'(status_out), 16'(steps[i].st));
      chk(16'(busy_out), 16'(steps[i].cyc > 4'h1));
      if (steps[i].cyc > 4'h2) begin
        tick(int'(steps[i].cyc) - 2);
        chk(16'(busy_out), 16'h0001);
      end
      // the last hold edge only drops busy; the next word runs one edge later
      if (steps[i].cyc > 4'h1) begin
        tick(1);
        chk(16'({busy_out, prog_addr_out}), 16'(steps[i].pc));
      end
    end
  endtask
  task automatic peek(input logic [4:0] a, input logic [7:0] e);
    rf_peek_addr_in = a;
    tick(1);
    chk(16'(rf_peek_data_out), 16'(e));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_flags();
    logic [15:0] wd [16] = '{16'hef0f, 16'h9503, 16'h950a, 16'h9506, 16'h2300, 16'h9503,
      16'h950a, 16'h0f00, 16'h9503, 16'hef1f, 16'h1701, 16'h9513, 16'h1701, 16'h0700,
      16'h0710, 16'h3f0f};
    logic [7:0] s [16] = '{8'h00, 8'h02, 8'h14, 8'h19, 8'h01, 8'h0d, 8'h19, 8'h0c, 8'h14,
      8'h14, 8'h02, 8'h02, 8'h14, 8'h00, 8'h21, 8'h02};
    wipe();
    for (int i = 0; i < 16; i++) begin
      mem[i] = wd[i];
      add_step(1, i + 1, s[i]);
    end
    run_steps();
    peek(5'h10, 8'hff);
    peek(5'h11, 8'h00);
  endtask
  // every status bit, both polarities, against five known flag patterns
  task automatic test_branches();
    logic [15:0] pre [5][4] = '{'{16'h0, 16'h0, 16'h0, 16'h0},
      '{16'hef0f, 16'h9506, 16'h0, 16'h0}, '{16'hef0f, 16'h2300, 16'h0, 16'h0},
      '{16'hef0f, 16'hef1f, 16'h9513, 16'h0710}, '{16'hef0f, 16'h9503, 16'h0, 16'h0}};
    logic [7:0] fin [5] = '{8'h00, 8'h19, 8'h14, 8'h21, 8'h02};
    logic taken;
    for (int p = 0; p < 5; p++) begin
      for (int s = 0; s < 16; s++) begin
        wipe();
        for (int i = 0; i < 4; i++) begin
          mem[i] = pre[p][i];
        end
        mem[4] = (s > 7 ? 16'hf428 : 16'hf028) | 16'(s % 8);
        taken = fin[p][s % 8] ^ (s > 7);
        rst_in = 1'b0;
        tick(5);
        chk(16'(status_out), 16'(fin[p]));
        chk(16'({busy_out, prog_addr_out}), taken ? 16'h080a : 16'h0005);
        tick(1);
        chk(16'({busy_out, prog_addr_out}), taken ? 16'h000a : 16'h0006);
      end
    end
  endtask
  // relative call, interrupt return, pointer call and jump, backward jump, plain return
  task automatic test_calls();
    int ad [11] = '{0, 10, 1, 3, 4, 5, 6, 11'h700, 11'h6fe, 7, 11'h700};
    logic [15:0] wd [10] = '{16'hd009, 16'h9518, 16'hf00f, 16'hefff, 16'hefef, 16'h95e3,
      16'h9509, 16'hcffd, 16'h9508, 16'h9409};
    int c [10] = '{3, 4, 2, 1, 1, 1, 3, 2, 4, 2};
    wipe();
    for (int i = 0; i < 10; i++) begin
      mem[ad[i]] = wd[i];
      add_step(c[i], ad[i + 1], i == 0 ? 8'h00 : (i < 5 ? 8'h80 : 8'h82));
    end
    run_steps();
  endtask
  // skips over one-word and two-word instructions, and skips not taken
  task automatic test_skips();
    logic [15:0] wd [24] = '{16'hef0f, 16'hef1f, 16'h1301, 16'h0, 16'h1301, 16'h940c, 16'h0,
      16'h9513, 16'h1301, 16'hfd10, 16'h0, 16'hff10, 16'hff07, 16'h940c, 16'h0, 16'hfd03,
      16'h992a, 16'h9b2a, 16'h0, 16'h99ff, 16'h940c, 16'h0, 16'h9bf8, 16'h0};
    int c [14] = '{1, 1, 2, 3, 1, 1, 2, 1, 3, 1, 1, 2, 3, 2};
    int p [14] = '{1, 2, 4, 7, 8, 9, 11, 12, 15, 16, 17, 19, 22, 24};
    wipe();
    io[5] = 8'h04;
    io[31] = 8'h7f;
    foreach (wd[i]) begin
      mem[i] = wd[i];
    end
    for (int i = 0; i < 14; i++) begin
      add_step(c[i], p[i], i < 4 ? 8'h00 : 8'h02);
    end
    run_steps();
  endtask
  // bit set at the top end and clear at the bottom end of the io range, then read back by skips
  task automatic test_io();
    logic [4:0] a [3] = '{5'h1f, 5'h00, 5'h12};
    logic [7:0] m [3] = '{8'h80, 8'h01, 8'h08};
    wipe();
    io[31] = 8'h7f;
    io[0] = 8'h01;
    mem[0] = 16'h9aff;
    mem[1] = 16'h9800;
    mem[2] = 16'h9a93;
    mem[3] = 16'h9bff;
    mem[5] = 16'h9900;
    rst_in = 1'b0;
    for (int i = 0; i < 3; i++) begin
      tick(1);
      chk(16'({io_wr_en_out, busy_out, io_wr_addr_out}), 16'({2'h3, a[i]}));
      chk({io_wr_mask_out, io_wr_data_out & io_wr_mask_out}, {m[i], i == 1 ? 8'h00 : m[i]});
      tick(1);
      chk(16'({io_wr_en_out, busy_out}), 16'h0000);
    end
    tick(1);
    chk(16'(prog_addr_out), 16'h0005);
    tick(2);
    chk(16'(prog_addr_out), 16'h0007);
    chk(16'(status_out), 16'h0000);
  endtask

  task automatic test_done();
    if (n_errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    foreach (io[i]) io[i] = 8'h00;
    test_flags();
    test_branches();
    test_calls();
    test_skips();
    test_io();
    test_done();
  end
endmodule
